/* File: ckc_params.svh */
/*
 * Offsets, field positions, reset values, encodings and timing counts
 * of the clock controller register bank.
 * Assumes a 125 MHz system clock and byte addresses within one 4 KB page.
 */
`ifndef CKC_PARAMS_SVH
`define CKC_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define CKC_OFF_HF_START    12'h000
`define CKC_OFF_HF_STOP     12'h004
`define CKC_OFF_LF_START    12'h008
`define CKC_OFF_LF_STOP     12'h00C
`define CKC_OFF_CAL         12'h010
`define CKC_OFF_CT_START    12'h014
`define CKC_OFF_CT_STOP     12'h018
`define CKC_OFF_INT_SET     12'h304
`define CKC_OFF_INT_CLR     12'h308
`define CKC_OFF_HF_RUN      12'h408
`define CKC_OFF_HF_STATE    12'h40C
`define CKC_OFF_LF_RUN      12'h414
`define CKC_OFF_LF_STATE    12'h418
`define CKC_OFF_LF_COPY     12'h41C
`define CKC_OFF_LF_SELECT   12'h518
`define CKC_OFF_DEBOUNCE    12'h528
`define CKC_OFF_CT_IV       12'h538
`define CKC_OFF_TRACE       12'h55C
`define CKC_OFF_RC_MODE     12'h5B4
`define CKC_OFF_EVT_STATUS  12'h600

// ==========================================================
// Field positions
`define CKC_SRC_LSB         0
`define CKC_BYPASS_BIT      16
`define CKC_EXT_BIT         17
`define CKC_RUNNING_BIT     16
`define CKC_TR_SPEED_LSB    0
`define CKC_TR_MUX_LSB      16
`define CKC_EV_HF           0
`define CKC_EV_LF           1
`define CKC_EV_CAL          2
`define CKC_EV_CT_TO        3
`define CKC_EV_CT_START     4
`define CKC_EV_CT_STOP      5

// ==========================================================
// Encodings and reset values
`define CKC_SRC_RC          2'h0
`define CKC_SRC_XTAL        2'h1
`define CKC_SRC_SYNTH       2'h2
`define CKC_MUX_GPIO        2'h0
`define CKC_MUX_SERIAL      2'h1
`define CKC_MUX_PARALLEL    2'h2
`define CKC_RESP_OKAY       2'h0
`define CKC_RESP_SLVERR     2'h2
`define CKC_RST_INT_EN      6'h00
`define CKC_RST_DEBOUNCE    8'h10
`define CKC_RST_CT_IV       7'h10
`define CKC_RST_TR_SPEED    2'h0
`define CKC_RST_TR_MUX      2'h0

// ==========================================================
// Timing: all sequencer counts are in 1 us ticks
`define CKC_CLK_NS          8
`define CKC_TICK_NS         1000
`define CKC_TICK_CYC        8'((`CKC_TICK_NS) / (`CKC_CLK_NS))
`define CKC_HF_POWERUP_US   16'h0040
`define CKC_LF_START_US     16'h00FA
`define CKC_CAL_US          16'h0064
`define CKC_TR_HALF_BASE    8'h04

`endif

/* File: ckc_pkg.sv */
/*
 * Types of the clock controller register bank.
 * Assumes nothing from ckc_params.svh; the state encodings are given here.
 */
package ckc_pkg;

    // ======================================================
    // Oscillator start sequencer states
    typedef enum logic [1:0] {
        CKC_OFF   = 2'b00,
        CKC_START = 2'b01,
        CKC_RUN   = 2'b10
    } ckc_osc_t;

    // ======================================================
    // Whole non-retained state of the bank
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic [1:0]  resp;
        logic [5:0]  irq_en;
        logic [5:0]  evt;
        ckc_osc_t    hf_st;
        logic        hf_trig;
        logic [15:0] hf_cnt;
        ckc_osc_t    lf_st;
        logic        lf_trig;
        logic [15:0] lf_cnt;
        logic [1:0]  lf_src;
        logic        lf_byp;
        logic        lf_ext;
        logic [1:0]  cp_src;
        logic        cp_byp;
        logic        cp_ext;
        logic        cal_busy;
        logic [15:0] cal_cnt;
        logic        ct_run;
        logic [6:0]  ct_cnt;
        logic [7:0]  debounce;
        logic        rc_ulp;
        logic        trc_clk;
    } ckc_st_t;

endpackage : ckc_pkg

/* File: ckc_div.sv */
/*
 * Programmable divider: one-cycle pulse every period_in clock cycles.
 * Assumes period_in is at least 1 and changes only rarely.
 */
module ckc_div (
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic [7:0] period_in,
    output logic            tick_out
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;

    always_comb begin
        if (cnt_r >= 8'(period_in - 8'h01)) begin
            cnt_nxt = 8'h00;
        end else begin
            cnt_nxt = 8'(cnt_r + 8'h01);
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Pulse on wrap; a shortened period takes effect at once
    assign tick_out = (cnt_r >= 8'(period_in - 8'h01));

endmodule : ckc_div

/* File: ckc_regbank.sv */
/*
 * Clock controller register bank: interrupt enables, start sequencers
 * for the fast and slow clocks, calibration and its timer, slow source
 * selection with snapshot, retained interval and trace port setup.
 * Assumes an Avalon-MM master on clk_in and separate power-on and debug
 * resets for the retained registers.
 */
// The implementer's own choice: the Avalon-MM register port.
// Operation
// - Writing one to enable-set bit enables that event; reads show enables
// - Writing one to enable-clear bit disables it; reads show enables
// - Six enables in fixed order, all disabled after reset
// - Read-only source snapshot captures select register on slow start
// - Source encoding: 0 RC, 1 crystal, 2 synthesized; same in snapshot
// - Bypass bit one means rail-to-rail external clock, zero means off
// - External bit uses external slow signal; software sets crystal source
// - Fast started event after power-up plus programmed debounce time
// - Read-only status shows fast start task was triggered
// - Read-only status shows slow start task was triggered
// - Calibration interval register survives ordinary resets
// - Trace speed 0..3 selects 32..4 MHz; pin gives half of it
// - Trace routing: 0 none, 1 serial output only, 2 clock plus data
// - Trace config retained, reset only by the debug reset
// - Mode register picks normal or ultra-low-power slow RC oscillator
`include "ckc_params.svh"

module ckc_regbank (
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        por_resetn_in,
    input  wire logic        dbg_resetn_in,
    input  wire logic [11:0] address_in,
    input  wire logic        read_in,
    input  wire logic        write_in,
    input  wire logic [31:0] writedata_in,
    input  wire logic [3:0]  byteenable_in,
    output logic [31:0]      readdata_out,
    output logic [1:0]       response_out,
    output logic             waitrequest_out,
    output logic             irq_out,
    output logic             fast_clock_out,
    output logic             slow_clock_out,
    output logic [1:0]       slow_source_out,
    output logic             slow_bypass_out,
    output logic             slow_external_out,
    output logic             slow_ulp_out,
    output logic             trace_clock_pin_out,
    output logic             trace_clock_oe_out,
    output logic             serial_wire_output_oe_out,
    output logic [3:0]       trace_data_pins_oe_out
);
    ckc_pkg::ckc_st_t s_r;
    ckc_pkg::ckc_st_t s_nxt;
    logic [6:0]       ct_iv_r;
    logic [1:0]       tr_speed_r;
    logic [1:0]       tr_mux_r;
    logic             us_tick;
    logic             trc_tick;
    logic             acc;
    logic             wr;
    logic [31:0]      wd;
    logic [5:0]       new_evt;

    // ======================================================
    // Slow source field packing, shared by select and snapshot
    function automatic logic [31:0] lf_pack(input logic [1:0] src,
                                            input logic byp,
                                            input logic ext);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[`CKC_SRC_LSB +: 2] = src;
        v[`CKC_BYPASS_BIT] = byp;
        v[`CKC_EXT_BIT] = ext;
        return v;
    endfunction : lf_pack

    // ======================================================
    // Tick sources
    ckc_div u_us_div (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .period_in (`CKC_TICK_CYC),
        .tick_out  (us_tick)
    );

    // Half-period 4/8/16/32 cycles: nearest to 32..4 MHz at 125 MHz
    ckc_div u_trc_div (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .period_in (8'(`CKC_TR_HALF_BASE << tr_speed_r)),
        .tick_out  (trc_tick)
    );

    // ======================================================
    // Bus acceptance: one wait state, write lands at the accept edge
    assign waitrequest_out = (read_in | write_in) & ~s_r.ack;
    assign acc = (read_in | write_in) & s_r.ack;
    assign wr = write_in & acc;
    assign wd = writedata_in & {{8{byteenable_in[3]}},
                                {8{byteenable_in[2]}},
                                {8{byteenable_in[1]}},
                                {8{byteenable_in[0]}}};

    function automatic logic hit(input logic [11:0] off);
        return wr && (address_in == off) && wd[0];
    endfunction : hit

    // ======================================================
    // Next state
    always_comb begin
        s_nxt = s_r;
        new_evt = 6'h00;
        s_nxt.ack = (read_in | write_in) & ~s_r.ack;

        // Read data is prepared one edge before the accept edge
        if (read_in && !s_r.ack) begin
            s_nxt.resp = `CKC_RESP_OKAY;
            s_nxt.rdata = 32'h0000_0000;
            case (address_in)
                `CKC_OFF_HF_START, `CKC_OFF_HF_STOP, `CKC_OFF_LF_START,
                `CKC_OFF_LF_STOP, `CKC_OFF_CAL, `CKC_OFF_CT_START,
                `CKC_OFF_CT_STOP: s_nxt.rdata = 32'h0000_0000;
                `CKC_OFF_INT_SET,
                `CKC_OFF_INT_CLR: s_nxt.rdata[5:0] = s_r.irq_en;
                `CKC_OFF_EVT_STATUS: s_nxt.rdata[5:0] = s_r.evt;
                `CKC_OFF_HF_RUN: s_nxt.rdata[0] = s_r.hf_trig;
                `CKC_OFF_HF_STATE: begin
                    s_nxt.rdata[0] = 1'b1;
                    s_nxt.rdata[`CKC_RUNNING_BIT] =
                        (s_r.hf_st == ckc_pkg::CKC_RUN);
                end
                `CKC_OFF_LF_RUN: s_nxt.rdata[0] = s_r.lf_trig;
                `CKC_OFF_LF_STATE: begin
                    s_nxt.rdata = lf_pack(s_r.cp_src, 1'b0, 1'b0);
                    s_nxt.rdata[`CKC_RUNNING_BIT] =
                        (s_r.lf_st == ckc_pkg::CKC_RUN);
                end
                `CKC_OFF_LF_COPY:
                    s_nxt.rdata = lf_pack(s_r.cp_src, s_r.cp_byp,
                                          s_r.cp_ext);
                `CKC_OFF_LF_SELECT:
                    s_nxt.rdata = lf_pack(s_r.lf_src, s_r.lf_byp,
                                          s_r.lf_ext);
                `CKC_OFF_DEBOUNCE: s_nxt.rdata[7:0] = s_r.debounce;
                `CKC_OFF_CT_IV: s_nxt.rdata[6:0] = ct_iv_r;
                `CKC_OFF_TRACE: begin
                    s_nxt.rdata[`CKC_TR_SPEED_LSB +: 2] = tr_speed_r;
                    s_nxt.rdata[`CKC_TR_MUX_LSB +: 2] = tr_mux_r;
                end
                `CKC_OFF_RC_MODE: s_nxt.rdata[0] = s_r.rc_ulp;
                default: s_nxt.resp = `CKC_RESP_SLVERR;
            endcase
        end else if (write_in && !s_r.ack) begin
            s_nxt.rdata = 32'h0000_0000;
            s_nxt.resp = `CKC_RESP_OKAY;
            case (address_in)
                `CKC_OFF_HF_START, `CKC_OFF_HF_STOP, `CKC_OFF_LF_START,
                `CKC_OFF_LF_STOP, `CKC_OFF_CAL, `CKC_OFF_CT_START,
                `CKC_OFF_CT_STOP, `CKC_OFF_INT_SET, `CKC_OFF_INT_CLR,
                `CKC_OFF_EVT_STATUS, `CKC_OFF_LF_SELECT, `CKC_OFF_DEBOUNCE,
                `CKC_OFF_CT_IV, `CKC_OFF_TRACE, `CKC_OFF_RC_MODE,
                `CKC_OFF_HF_RUN, `CKC_OFF_HF_STATE, `CKC_OFF_LF_RUN,
                `CKC_OFF_LF_STATE, `CKC_OFF_LF_COPY: s_nxt.resp =
                    `CKC_RESP_OKAY;
                default: s_nxt.resp = `CKC_RESP_SLVERR;
            endcase
        end

        // Plain configuration writes; reserved bits are dropped
        if (wr) begin
            case (address_in)
                `CKC_OFF_INT_SET:
                    s_nxt.irq_en = s_r.irq_en | wd[5:0];
                `CKC_OFF_INT_CLR:
                    s_nxt.irq_en = s_r.irq_en & ~wd[5:0];
                `CKC_OFF_LF_SELECT: begin
                    // Unused code 3 is refused, old source kept
                    if (wd[`CKC_SRC_LSB +: 2] != 2'h3) begin
                        s_nxt.lf_src = wd[`CKC_SRC_LSB +: 2];
                    end
                    s_nxt.lf_byp = wd[`CKC_BYPASS_BIT];
                    s_nxt.lf_ext = wd[`CKC_EXT_BIT];
                end
                `CKC_OFF_DEBOUNCE: s_nxt.debounce = wd[7:0];
                `CKC_OFF_RC_MODE: s_nxt.rc_ulp = wd[0];
                default: s_nxt.debounce = s_nxt.debounce;
            endcase
        end

        // Fast clock sequencer
        case (s_r.hf_st)
            ckc_pkg::CKC_OFF: begin
                if (hit(`CKC_OFF_HF_START)) begin
                    s_nxt.hf_st = ckc_pkg::CKC_START;
                    s_nxt.hf_cnt = 16'(`CKC_HF_POWERUP_US
                                       + {8'h00, s_r.debounce});
                end
            end
            ckc_pkg::CKC_START: begin
                if (us_tick) begin
                    if (s_r.hf_cnt == 16'h0000) begin
                        s_nxt.hf_st = ckc_pkg::CKC_RUN;
                        new_evt[`CKC_EV_HF] = 1'b1;
                    end else begin
                        s_nxt.hf_cnt = 16'(s_r.hf_cnt - 16'h0001);
                    end
                end
            end
            ckc_pkg::CKC_RUN: s_nxt.hf_st = ckc_pkg::CKC_RUN;
            default: s_nxt.hf_st = ckc_pkg::CKC_OFF;
        endcase
        if (hit(`CKC_OFF_HF_START)) begin
            s_nxt.hf_trig = 1'b1;
        end
        if (hit(`CKC_OFF_HF_STOP)) begin
            s_nxt.hf_trig = 1'b0;
            s_nxt.hf_st = ckc_pkg::CKC_OFF;
        end

        // Slow clock sequencer
        case (s_r.lf_st)
            ckc_pkg::CKC_OFF: begin
                if (hit(`CKC_OFF_LF_START)) begin
                    s_nxt.lf_st = ckc_pkg::CKC_START;
                    s_nxt.lf_cnt = `CKC_LF_START_US;
                end
            end
            ckc_pkg::CKC_START: begin
                if (us_tick) begin
                    if (s_r.lf_cnt == 16'h0000) begin
                        s_nxt.lf_st = ckc_pkg::CKC_RUN;
                        new_evt[`CKC_EV_LF] = 1'b1;
                    end else begin
                        s_nxt.lf_cnt = 16'(s_r.lf_cnt - 16'h0001);
                    end
                end
            end
            ckc_pkg::CKC_RUN: s_nxt.lf_st = ckc_pkg::CKC_RUN;
            default: s_nxt.lf_st = ckc_pkg::CKC_OFF;
        endcase
        if (hit(`CKC_OFF_LF_START)) begin
            s_nxt.lf_trig = 1'b1;
            s_nxt.cp_src = s_r.lf_src;
            s_nxt.cp_byp = s_r.lf_byp;
            s_nxt.cp_ext = s_r.lf_ext;
        end
        if (hit(`CKC_OFF_LF_STOP)) begin
            s_nxt.lf_trig = 1'b0;
            s_nxt.lf_st = ckc_pkg::CKC_OFF;
        end

        // Calibration: one timed pass per task, needs no fast clock here
        if (hit(`CKC_OFF_CAL) && !s_r.cal_busy) begin
            s_nxt.cal_busy = 1'b1;
            s_nxt.cal_cnt = `CKC_CAL_US;
        end else if (s_r.cal_busy && us_tick) begin
            if (s_r.cal_cnt == 16'h0000) begin
                s_nxt.cal_busy = 1'b0;
                new_evt[`CKC_EV_CAL] = 1'b1;
            end else begin
                s_nxt.cal_cnt = 16'(s_r.cal_cnt - 16'h0001);
            end
        end

        // Calibration timer counts down from the retained interval
        if (hit(`CKC_OFF_CT_START)) begin
            new_evt[`CKC_EV_CT_START] = 1'b1;
            if (!s_r.ct_run) begin
                s_nxt.ct_run = 1'b1;
                s_nxt.ct_cnt = ct_iv_r;
            end
        end else if (hit(`CKC_OFF_CT_STOP)) begin
            new_evt[`CKC_EV_CT_STOP] = 1'b1;
            s_nxt.ct_run = 1'b0;
        end else if (s_r.ct_run && us_tick) begin
            if (s_r.ct_cnt == 7'h00) begin
                s_nxt.ct_run = 1'b0;
                new_evt[`CKC_EV_CT_TO] = 1'b1;
            end else begin
                s_nxt.ct_cnt = 7'(s_r.ct_cnt - 7'h01);
            end
        end

        // Sticky flags: a new event beats a one-write clear
        if (wr && address_in == `CKC_OFF_EVT_STATUS) begin
            s_nxt.evt = s_r.evt & ~wd[5:0];
        end
        s_nxt.evt = s_nxt.evt | new_evt;

        // Trace clock pin only toggles when routed
        if (tr_mux_r == `CKC_MUX_PARALLEL) begin
            s_nxt.trc_clk = s_r.trc_clk ^ trc_tick;
        end else begin
            s_nxt.trc_clk = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_r <= '{ack: 1'b0, rdata: 32'h0000_0000,
                     resp: `CKC_RESP_OKAY, irq_en: `CKC_RST_INT_EN,
                     evt: 6'h00, hf_st: ckc_pkg::CKC_OFF,
                     hf_trig: 1'b0, hf_cnt: 16'h0000,
                     lf_st: ckc_pkg::CKC_OFF, lf_trig: 1'b0,
                     lf_cnt: 16'h0000, lf_src: `CKC_SRC_RC,
                     lf_byp: 1'b0, lf_ext: 1'b0, cp_src: `CKC_SRC_RC,
                     cp_byp: 1'b0, cp_ext: 1'b0, cal_busy: 1'b0,
                     cal_cnt: 16'h0000, ct_run: 1'b0, ct_cnt: 7'h00,
                     debounce: `CKC_RST_DEBOUNCE, rc_ulp: 1'b0,
                     trc_clk: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ======================================================
    // Retained registers on their own resets
    always_ff @(posedge clk_in or negedge por_resetn_in) begin
        if (!por_resetn_in) begin
            ct_iv_r <= `CKC_RST_CT_IV;
        end else if (wr && address_in == `CKC_OFF_CT_IV) begin
            ct_iv_r <= wd[6:0];
        end
    end

    always_ff @(posedge clk_in or negedge dbg_resetn_in) begin
        if (!dbg_resetn_in) begin
            tr_speed_r <= `CKC_RST_TR_SPEED;
            tr_mux_r <= `CKC_RST_TR_MUX;
        end else if (wr && address_in == `CKC_OFF_TRACE) begin
            tr_speed_r <= wd[`CKC_TR_SPEED_LSB +: 2];
            if (wd[`CKC_TR_MUX_LSB +: 2] != 2'h3) begin
                tr_mux_r <= wd[`CKC_TR_MUX_LSB +: 2];
            end
        end
    end

    // ======================================================
    // Outputs
    assign readdata_out = s_r.rdata;
    assign response_out = s_r.resp;
    assign irq_out = |(s_r.evt & s_r.irq_en);
    assign fast_clock_out = (s_r.hf_st == ckc_pkg::CKC_RUN);
    assign slow_clock_out = (s_r.lf_st == ckc_pkg::CKC_RUN);
    assign slow_source_out = s_r.cp_src;
    assign slow_bypass_out = s_r.cp_byp;
    // External only counts with crystal source selected
    assign slow_external_out = s_r.cp_ext
                               && (s_r.cp_src == `CKC_SRC_XTAL);
    assign slow_ulp_out = s_r.rc_ulp;
    assign trace_clock_pin_out = s_r.trc_clk;
    assign trace_clock_oe_out = (tr_mux_r == `CKC_MUX_PARALLEL);
    assign serial_wire_output_oe_out = (tr_mux_r == `CKC_MUX_SERIAL);
    assign trace_data_pins_oe_out = {4{tr_mux_r == `CKC_MUX_PARALLEL}};

    // ======================================================
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    irq_cause_a: assert property (|(new_evt & s_nxt.irq_en)
                                  |=> irq_out)
        else $error("enabled event gave no irq");
    en_set_a: assert property (wr && address_in == `CKC_OFF_INT_SET
                               && wd[`CKC_EV_CT_TO] |=> s_r.irq_en[3])
        else $error("enable set lost");
    en_clr_a: assert property (wr && address_in == `CKC_OFF_INT_CLR
                               && wd[`CKC_EV_HF] |=> !s_r.irq_en[0])
        else $error("enable clear lost");
    en_read_a: assert property (read_in && !s_r.ack &&
                                address_in == `CKC_OFF_INT_CLR
                                |=> readdata_out == {26'h0, s_r.irq_en})
        else $error("enable readback wrong");
    snap_cap_a: assert property (hit(`CKC_OFF_LF_START)
                                 |=> s_r.cp_src == $past(s_r.lf_src))
        else $error("snapshot not captured");
    src_code_a: assert property (s_r.lf_src != 2'h3)
        else $error("bad source code");
    hf_event_a: assert property ($rose(s_r.evt[`CKC_EV_HF])
                       |-> $past(s_r.hf_st) == ckc_pkg::CKC_START
                           && $past(s_r.hf_cnt) == 16'h0000)
        else $error("fast event early");
    hf_run_a: assert property (hit(`CKC_OFF_HF_START)
                               |=> s_r.hf_trig [*2])
        else $error("fast run status missing");
    lf_run_a: assert property (hit(`CKC_OFF_LF_START)
                               |=> s_r.lf_trig)
        else $error("slow run status missing");
    wait_one_a: assert property ((read_in || write_in) && !s_r.ack
                                 |=> !waitrequest_out)
        else $error("slave stalled too long");

    irq_seen_c: cover property ($rose(irq_out));
    hf_up_c: cover property ($rose(fast_clock_out));
    ct_to_c: cover property ($rose(s_r.evt[`CKC_EV_CT_TO]));

endmodule : ckc_regbank

/* File: testbench.sv */
/* Self-checking bench of the clock controller register bank.
   Assumes ckc_regbank and ckc_params.svh; drives Avalon-MM itself. */
`include "ckc_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 0, resetn_in = 0, por_resetn_in = 0;
    logic        dbg_resetn_in = 0, read_in = 0, write_in = 0;
    logic [11:0] address_in = 12'h000;
    logic [31:0] writedata_in = 32'h00000000, q, readdata_out;
    logic [1:0]  rs, response_out, slow_source_out;
    logic [3:0]  trace_data_pins_oe_out;
    logic        waitrequest_out, irq_out, fast_clock_out, slow_clock_out;
    logic        slow_bypass_out, slow_external_out, slow_ulp_out;
    logic        trace_clock_pin_out, trace_clock_oe_out;
    logic        serial_wire_output_oe_out, p;
    int          errors = 0, n_tests = 0, cyc = 0, n;
    ckc_regbank u_dut (.clk_in(clk_in), .resetn_in(resetn_in),
        .por_resetn_in(por_resetn_in), .dbg_resetn_in(dbg_resetn_in),
        .address_in(address_in), .read_in(read_in), .write_in(write_in),
        .writedata_in(writedata_in), .byteenable_in(4'hF),
        .readdata_out(readdata_out), .response_out(response_out),
        .waitrequest_out(waitrequest_out), .irq_out(irq_out),
        .fast_clock_out(fast_clock_out), .slow_clock_out(slow_clock_out),
        .slow_source_out(slow_source_out), .slow_bypass_out(slow_bypass_out),
        .slow_external_out(slow_external_out), .slow_ulp_out(slow_ulp_out),
        .trace_clock_pin_out(trace_clock_pin_out),
        .trace_clock_oe_out(trace_clock_oe_out),
        .serial_wire_output_oe_out(serial_wire_output_oe_out),
        .trace_data_pins_oe_out(trace_data_pins_oe_out));
    always #4 clk_in = ~clk_in;
    // ========================================
    // Reporting and bus access
    task complete_run;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            complete_run();
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Request held until waitrequest sampled low at a rising edge
    task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        address_in <= a;
        writedata_in <= d;
        write_in <= wr;
        read_in <= !wr;
        do @(posedge clk_in); while (waitrequest_out !== 1'b0);
        q = readdata_out;
        rs = response_out;
        write_in <= 1'b0;
        read_in <= 1'b0;
    endtask : bus
    // ========================================
    // Scenarios
    task t_enable;
        bus(1'b0, `CKC_OFF_INT_SET, 32'h0);
        chk("en_reset", 32'h00000000, q);
        bus(1'b1, `CKC_OFF_INT_SET, 32'h0000003F);
        bus(1'b0, `CKC_OFF_INT_CLR, 32'h0);
        chk("en_all", 32'h0000003F, q);
        bus(1'b1, `CKC_OFF_INT_CLR, 32'h00000005);
        bus(1'b1, `CKC_OFF_INT_SET, 32'h00000000);
        bus(1'b0, `CKC_OFF_INT_SET, 32'h0);
        chk("en_part", 32'h0000003A, q);
        bus(1'b1, `CKC_OFF_INT_CLR, 32'hFFFFFFFF);
        bus(1'b0, `CKC_OFF_INT_CLR, 32'h0);
        chk("en_none", 32'h00000000, q);
    endtask : t_enable
    task t_irq;
        bus(1'b1, `CKC_OFF_INT_SET, 32'h00000010);
        bus(1'b1, `CKC_OFF_CT_START, 32'h00000001);
        repeat (3) @(negedge clk_in);
        chk("irq_on", 32'h1, irq_out);
        bus(1'b1, `CKC_OFF_INT_CLR, 32'h00000010);
        @(negedge clk_in);
        chk("irq_masked", 32'h0, irq_out);
        bus(1'b1, `CKC_OFF_INT_SET, 32'h00000010);
        @(negedge clk_in);
        chk("irq_again", 32'h1, irq_out);
        bus(1'b1, `CKC_OFF_EVT_STATUS, 32'h00000010);
        @(negedge clk_in);
        chk("irq_clear", 32'h0, irq_out);
    endtask : t_irq
    task t_clocks;
        bus(1'b0, `CKC_OFF_HF_RUN, 32'h0);
        chk("hf_idle", 32'h00000000, q);
        bus(1'b1, `CKC_OFF_DEBOUNCE, 32'h00000010);
        bus(1'b1, `CKC_OFF_HF_START, 32'h00000001);
        bus(1'b0, `CKC_OFF_HF_RUN, 32'h0);
        chk("hf_run", 32'h00000001, q);
        bus(1'b1, `CKC_OFF_LF_SELECT, 32'h00030001);
        bus(1'b1, `CKC_OFF_LF_START, 32'h00000001);
        bus(1'b1, `CKC_OFF_LF_SELECT, 32'h00000002);
        bus(1'b0, `CKC_OFF_LF_COPY, 32'h0);
        chk("copy", 32'h00030001, q);
        chk("src_pin", 32'h1, slow_source_out);
        chk("ext_pin", 32'h1, slow_external_out);
        bus(1'b0, `CKC_OFF_LF_RUN, 32'h0);
        chk("lf_run", 32'h00000001, q);
        chk("byp_pin", 32'h1, slow_bypass_out);
        // Start accepted 18 edges ago; 80 us is 10000 cycles
        repeat (9970) @(posedge clk_in);
        chk("hf_early", 32'h0, fast_clock_out | slow_clock_out);
        repeat (260) @(posedge clk_in);
        chk("hf_up", 32'h1, fast_clock_out);
    endtask : t_clocks
    task t_trace;
        bus(1'b1, `CKC_OFF_TRACE, 32'h00020000);
        n = 0;
        p = trace_clock_pin_out;
        repeat (64) begin
            @(posedge clk_in);
            n += (trace_clock_pin_out != p);
            p = trace_clock_pin_out;
        end
        chk("trc_fast", 32'h1, n >= 15 && n <= 17);
        chk("data_oe", 32'hF, trace_data_pins_oe_out);
        bus(1'b1, `CKC_OFF_CT_IV, 32'h00000055);
        resetn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        chk("trc_kept", 32'h1, trace_clock_oe_out);
        bus(1'b0, `CKC_OFF_CT_IV, 32'h0);
        chk("iv_kept", 32'h00000055, q);
        bus(1'b1, `CKC_OFF_RC_MODE, 32'h00000001);
        bus(1'b1, `CKC_OFF_TRACE, 32'h00010000);
        @(negedge clk_in);
        chk("ulp_pin", 32'h1, slow_ulp_out);
        chk("swo_oe", 32'h1, serial_wire_output_oe_out);
        chk("clk_oe", 32'h0, trace_clock_oe_out);
        bus(1'b0, 12'h0FC, 32'h0);
        chk("unmapped", {30'h0, `CKC_RESP_SLVERR}, {q[29:0], rs});
    endtask : t_trace
    initial begin
        repeat (3) @(posedge clk_in);
        resetn_in <= 1'b1;
        por_resetn_in <= 1'b1;
        dbg_resetn_in <= 1'b1;
        t_enable();
        t_irq();
        t_clocks();
        t_trace();
        complete_run();
    end
endmodule : testbench
